// file: hdl/cgt_map.svh
`ifndef CGT_MAP_SVH
`define CGT_MAP_SVH
// Register byte offsets
`define CGT_CTRL_OFF 8'h00
`define CGT_LOW_OFF 8'h04
`define CGT_HIGH_OFF 8'h08
`define CGT_OUTCTL_OFF 8'h0c
`define CGT_ENV_OFF 8'h10
`define CGT_STAT_OFF 8'h14
// Control register fields
`define CGT_CTRL_RUN_BIT 0
`define CGT_CTRL_ENV_RUN_BIT 1
`define CGT_CTRL_CKS_LSB 4
`define CGT_CTRL_CKS_W 3
// Output control fields
`define CGT_OUT_MASTER_BIT 0
`define CGT_OUT_SELECT_BIT 1
`define CGT_OUT_ACTIVE_BIT 2
// Status fields
`define CGT_STAT_SYNC_BIT 0
`define CGT_STAT_CARRIER_BIT 1
`define CGT_STAT_PHASE_BIT 2
// Reset values
`define CGT_LOW_RST 8'h01
`define CGT_HIGH_RST 8'h01
`define CGT_ENV_RST 8'h01
// Timing
`define CGT_HIGH_XFER_CLKS 3
`define CGT_ACTIVE_DELAY 2
// AXI responses
`define CGT_RESP_OKAY 2'b00
`define CGT_RESP_SLVERR 2'b10
`endif

// file: hdl/cgt_pkg.sv
package cgt_pkg;
  typedef enum logic [1:0]
  {
    CGT_PH_LOW = 2'b01,
    CGT_PH_HIGH = 2'b10
  } cgt_phase_e;
  typedef struct packed
  {
    logic run;
    logic env_run;
    logic [2:0] clk_sel;
  } cgt_ctrl_s;
  typedef struct packed
  {
    logic master;
    logic select;
  } cgt_out_s;
endpackage : cgt_pkg

// file: hdl/cgt_prescaler.sv
`timescale 1ns/1ps
// Divides aclk by 2**sel into a one-cycle count enable
module cgt_prescaler #(
  parameter int WIDTH = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic [2:0] sel,
  output logic tick
);
  // Largest select is 7, so the divider needs at least seven bits
  if (WIDTH < 7)
  begin : g_width_check
    $error("cgt_prescaler WIDTH too small");
  end
  logic [WIDTH-1:0] div;
  logic [WIDTH-1:0] mask;
  assign mask = WIDTH'((1 << sel) - 1);
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !run)
      div <= '0;
    else
      div <= div + WIDTH'(1);
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !run)
      tick <= 1'b0;
    else
      tick <= ((div & mask) == '0);
  end
endmodule : cgt_prescaler

// file: hdl/cgt_envelope.sv
`timescale 1ns/1ps
`include "cgt_map.svh"
// Companion interval counter: match pulse on count equal to compare
module cgt_envelope (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic tick,
  input wire logic [7:0] compare,
  output logic match
);
  logic [7:0] count;
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !run)
      count <= 8'h00;
    else if (tick && count == compare)
      count <= 8'h00; // see RQ25
    else if (tick)
      count <= count + 8'h01;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !run)
      match <= 1'b0;
    else if (tick)
      match <= (count == compare); // see RQ25
  end
endmodule : cgt_envelope

// file: hdl/cgt_top.sv
`timescale 1ns/1ps
`include "cgt_map.svh"
// Contract
// RQ1: Low-width compare sets low phase; high-width compare sets high phase.
// RQ2: Software may rewrite high width while running, never low width.
// RQ3: Select 0: pin follows enable; select 1: enable gates carrier.
// RQ4: Enable is double-buffered: writable master, read-only active copy.
// RQ5: Envelope match resynchronised to carrier count clock as transfer strobe.
// RQ6: Master copies to active on second count clock after sync rise.
// RQ7: Software writes next enable and envelope compare after sync irq.
// RQ8: Software waits two clocks between master enable writes.
// RQ9: Envelope interrupt appears at synchronised timing in carrier mode.
// RQ10: Run bit starts carrier timer; separate run bit starts envelope.
// RQ11: Start compares low width; match pulses irq, clears, goes high.
// RQ12: High match pulses irq, clears, returns to low; repeats.
// RQ13: Carrier clock starts at default level, inverts on every match.
// RQ14: Active enable rising passes carrier from next carrier rising edge.
// RQ15: Active enable falling in high phase keeps pin high to phase end.
// RQ16: Period is N+M+2 count clocks, M+1 of them high.
// RQ17: New high width applied at old match, needs three count clocks.
// RQ18: Software rewrites high width after every restart.
// RQ19: Software keeps both widths within 01 to FF.
// RQ20: Software sets output select before starting.
// RQ21: Carrier count clock at least six times envelope clock.
// RQ22: Clearing run bit stops counting.
// RQ23: On stop, irq and pin return to default levels.
// RQ24: Counting begins within one count clock of run.
// RQ25: Envelope counter matches compare, clears and restarts the interval.
module cgt_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [2:0] env_clk_sel,
  output logic carrier_out_pin,
  output logic carrier_timer_irq,
  output logic envelope_sync_irq
);
  cgt_pkg::cgt_ctrl_s ctrl;
  cgt_pkg::cgt_out_s outc;
  cgt_pkg::cgt_phase_e phase;
  logic [7:0] low_width_compare;
  logic [7:0] high_width_compare;
  logic [7:0] high_pending;
  logic high_pend_valid;
  logic [1:0] high_age;
  logic [7:0] envelope_compare;
  logic carrier_enable_active;
  logic carrier_clk;
  logic hold_high;
  logic [7:0] count;
  logic tick;
  logic env_tick;
  logic [2:0] env_sel_q1;
  logic [2:0] env_sel_q2;
  logic envelope_match_irq;
  logic env_seen;
  logic sync_q;
  logic sync_rise;
  logic [1:0] xfer_cnt;
  logic sync_flag;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic master_wr;
  logic high_wr;
  logic [7:0] cmp_value;
  logic match;
  logic [31:0] next_rdata;

  // Bus write side: address and data accepted in any order
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign master_wr = do_write && aw_addr == `CGT_OUTCTL_OFF && w_strb[0];
  assign high_wr = do_write && aw_addr == `CGT_HIGH_OFF && w_strb[0];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held <= 1'b1;
      aw_addr <= {s_axi_awaddr[7:2], 2'b00};
    end
    else if (do_write)
      aw_held <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
    else if (do_write)
      w_held <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CGT_RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      case (aw_addr)
        `CGT_CTRL_OFF, `CGT_LOW_OFF, `CGT_HIGH_OFF, `CGT_OUTCTL_OFF,
        `CGT_ENV_OFF, `CGT_STAT_OFF:
          s_axi_bresp <= `CGT_RESP_OKAY;
        default:
          s_axi_bresp <= `CGT_RESP_SLVERR;
      endcase
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Register stores; byte lane 0 carries every field
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl <= '0;
      low_width_compare <= `CGT_LOW_RST;
      envelope_compare <= `CGT_ENV_RST;
      outc <= '0;
    end
    else if (do_write && w_strb[0])
    begin
      case (aw_addr)
        `CGT_CTRL_OFF:
        begin
          ctrl.run <= w_data[`CGT_CTRL_RUN_BIT]; // see RQ10 see RQ22
          ctrl.env_run <= w_data[`CGT_CTRL_ENV_RUN_BIT]; // see RQ10
          ctrl.clk_sel <= w_data[`CGT_CTRL_CKS_LSB +: `CGT_CTRL_CKS_W];
        end
        `CGT_LOW_OFF:
          low_width_compare <= w_data[7:0];
        `CGT_OUTCTL_OFF:
        begin
          outc.master <= w_data[`CGT_OUT_MASTER_BIT]; // see RQ4
          outc.select <= w_data[`CGT_OUT_SELECT_BIT];
        end
        `CGT_ENV_OFF:
          envelope_compare <= w_data[7:0];
        default:
        begin
        end
      endcase
    end
  end

  // Read side
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case (s_axi_araddr & 8'hfc)
      `CGT_CTRL_OFF:
      begin
        next_rdata[`CGT_CTRL_RUN_BIT] = ctrl.run;
        next_rdata[`CGT_CTRL_ENV_RUN_BIT] = ctrl.env_run;
        next_rdata[`CGT_CTRL_CKS_LSB +: `CGT_CTRL_CKS_W] = ctrl.clk_sel;
      end
      `CGT_LOW_OFF:
        next_rdata[7:0] = low_width_compare;
      `CGT_HIGH_OFF:
        next_rdata[7:0] = high_pend_valid ? high_pending : high_width_compare;
      `CGT_OUTCTL_OFF:
      begin
        next_rdata[`CGT_OUT_MASTER_BIT] = outc.master;
        next_rdata[`CGT_OUT_SELECT_BIT] = outc.select;
        next_rdata[`CGT_OUT_ACTIVE_BIT] = carrier_enable_active; // see RQ4
      end
      `CGT_ENV_OFF:
        next_rdata[7:0] = envelope_compare;
      `CGT_STAT_OFF:
      begin
        next_rdata[`CGT_STAT_SYNC_BIT] = sync_flag;
        next_rdata[`CGT_STAT_CARRIER_BIT] = carrier_clk;
        next_rdata[`CGT_STAT_PHASE_BIT] = (phase == cgt_pkg::CGT_PH_HIGH);
      end
      default:
        next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `CGT_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= (s_axi_araddr[7:2] > `CGT_STAT_OFF >> 2) ?
        `CGT_RESP_SLVERR : `CGT_RESP_OKAY;
    end
    else if (s_axi_rvalid)
    begin
      if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
    else
      s_axi_arready <= 1'b1;
  end

  // Clocks for the carrier timer and envelope counter
  cgt_prescaler #(.WIDTH(8)) u_carrier_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(ctrl.run),
    .sel(ctrl.clk_sel),
    .tick(tick)
  ); // see RQ24

  // Envelope clock select comes from a pin: two stages before use
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      env_sel_q1 <= 3'h0;
      env_sel_q2 <= 3'h0;
    end
    else
    begin
      env_sel_q1 <= env_clk_sel;
      env_sel_q2 <= env_sel_q1;
    end
  end

  cgt_prescaler #(.WIDTH(8)) u_env_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(ctrl.env_run),
    .sel(env_sel_q2),
    .tick(env_tick)
  );

  cgt_envelope u_env (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(ctrl.env_run),
    .tick(env_tick),
    .compare(envelope_compare),
    .match(envelope_match_irq)
  ); // see RQ25

  // Carrier counter and phase
  assign cmp_value = (phase == cgt_pkg::CGT_PH_LOW) ?
    low_width_compare : high_width_compare; // see RQ1
  assign match = tick && count == cmp_value;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !ctrl.run)
    begin
      count <= 8'h00; // see RQ22
      phase <= cgt_pkg::CGT_PH_LOW; // see RQ11
    end
    else if (match)
    begin
      count <= 8'h00; // see RQ11 see RQ12 see RQ16
      phase <= (phase == cgt_pkg::CGT_PH_LOW) ?
        cgt_pkg::CGT_PH_HIGH : cgt_pkg::CGT_PH_LOW; // see RQ12
    end
    else if (tick)
      count <= count + 8'h01;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !ctrl.run)
      carrier_clk <= 1'b0; // see RQ13 see RQ23
    else if (match)
      carrier_clk <= !carrier_clk; // see RQ13
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !ctrl.run)
      carrier_timer_irq <= 1'b0; // see RQ23
    else
      carrier_timer_irq <= match; // see RQ11 see RQ12
  end

  // High width latch: new value taken at old match after three count clocks
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      high_width_compare <= `CGT_HIGH_RST;
      high_pending <= `CGT_HIGH_RST;
      high_pend_valid <= 1'b0;
      high_age <= 2'd0;
    end
    else if (high_wr)
    begin
      high_pending <= w_data[7:0];
      high_pend_valid <= 1'b1;
      high_age <= 2'd0;
      if (!ctrl.run)
        high_width_compare <= w_data[7:0]; // see RQ18
    end
    else if (high_pend_valid && ctrl.run)
    begin
      if (match && phase == cgt_pkg::CGT_PH_HIGH &&
          high_age >= 2'(`CGT_HIGH_XFER_CLKS))
      begin
        high_width_compare <= high_pending; // see RQ17
        high_pend_valid <= 1'b0;
      end
      else if (tick && high_age != 2'd3)
        high_age <= high_age + 2'd1; // see RQ17
    end
  end

  // Envelope match held until the carrier clock samples it
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !ctrl.run)
      env_seen <= 1'b0;
    else if (envelope_match_irq)
      env_seen <= 1'b1;
    else if (tick)
      env_seen <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !ctrl.run)
      sync_q <= 1'b0;
    else if (tick)
      sync_q <= env_seen || envelope_match_irq; // see RQ5
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !ctrl.run)
      envelope_sync_irq <= 1'b0;
    else
      envelope_sync_irq <= tick && (env_seen || envelope_match_irq) &&
        !sync_q; // see RQ5 see RQ9
  end

  assign sync_rise = envelope_sync_irq;

  // Active copy loads on the second count clock after the sync pulse
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !ctrl.run)
      xfer_cnt <= 2'd0;
    else if (sync_rise)
      xfer_cnt <= 2'(`CGT_ACTIVE_DELAY);
    else if (tick && xfer_cnt != 2'd0)
      xfer_cnt <= xfer_cnt - 2'd1; // see RQ6
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      carrier_enable_active <= 1'b0;
    else if (tick && xfer_cnt == 2'd1)
      carrier_enable_active <= outc.master; // see RQ6
  end

  // Request flag: set wins over software clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sync_flag <= 1'b0;
    else if (sync_rise)
      sync_flag <= 1'b1;
    else if (do_write && aw_addr == `CGT_STAT_OFF && w_strb[0] &&
             w_data[`CGT_STAT_SYNC_BIT])
      sync_flag <= 1'b0;
  end

  // Gate: carrier passes from a rising edge, high phase never cut short
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !ctrl.run)
      hold_high <= 1'b0;
    else if (match && !carrier_clk)
      hold_high <= carrier_enable_active; // see RQ14
    else if (match && carrier_clk)
      hold_high <= 1'b0; // see RQ15
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !ctrl.run)
      carrier_out_pin <= 1'b0; // see RQ23
    else if (!outc.select)
      carrier_out_pin <= carrier_enable_active; // see RQ3
    else
      carrier_out_pin <= hold_high && carrier_clk; // see RQ3 see RQ15
  end

  wire unused_master_wr = master_wr;
endmodule : cgt_top

// file: tb/cgt_top_sva.sv
`timescale 1ns/1ps
`include "cgt_map.svh"
module cgt_top_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic carrier_out_pin,
  input wire logic carrier_timer_irq,
  input wire logic envelope_sync_irq
);
  logic [7:0] aw_last;
  logic [7:0] ar_last;
  // Remembers the last accepted addresses to judge the responses
  always_ff @(posedge aclk)
  begin
    if (s_axi_awvalid && s_axi_awready)
      aw_last <= s_axi_awaddr;
    if (s_axi_arvalid && s_axi_arready)
      ar_last <= s_axi_araddr;
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_irq_pulse:
    assert property (carrier_timer_irq |=> !carrier_timer_irq)
    else $error("carrier irq longer than one cycle");
  a_sync_gap:
    assert property (envelope_sync_irq |=> !envelope_sync_irq [*8])
    else $error("sync irq pulses too close");
  a_bvalid_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rvalid_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_write_answer:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read data late");
  a_write_resp:
    assert property (s_axi_bvalid |-> s_axi_bresp == (aw_last > `CGT_STAT_OFF
      ? `CGT_RESP_SLVERR : `CGT_RESP_OKAY))
    else $error("wrong write response");
  a_read_resp:
    assert property (s_axi_rvalid |-> (ar_last > `CGT_STAT_OFF) ?
      (s_axi_rresp == `CGT_RESP_SLVERR && s_axi_rdata == 32'h0) :
      s_axi_rresp == `CGT_RESP_OKAY)
    else $error("wrong read response");
  c_irq: cover property (carrier_timer_irq);
  c_pass: cover property (envelope_sync_irq ##[1:4] $rose(carrier_out_pin));
  c_err: cover property (s_axi_bvalid && s_axi_bresp == `CGT_RESP_SLVERR);
endmodule : cgt_top_sva
bind cgt_top cgt_top_sva u_sva (.*);

// file: tb/cgt_pin_monitor.sv
`timescale 1ns/1ps
// Receiver on the carrier pin: measures high and low run lengths
module cgt_pin_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clr,
  input wire logic pin,
  output logic [15:0] last_high,
  output logic [15:0] last_low,
  output logic [15:0] min_high
);
  logic [15:0] run_len;
  logic prev;
  always_ff @(posedge aclk)
  begin
    if (!aresetn || clr)
    begin
      run_len <= 16'h0;
      prev <= 1'b0;
      last_high <= 16'h0;
      last_low <= 16'h0;
      min_high <= 16'hffff;
    end
    else
    begin
      prev <= pin;
      run_len <= (pin == prev) ? run_len + 16'h1 : 16'h1;
      if (pin != prev && prev)
        last_high <= run_len;
      if (pin != prev && prev && run_len < min_high)
        min_high <= run_len;
      if (pin != prev && !prev)
        last_low <= run_len;
    end
  end
endmodule : cgt_pin_monitor

// file: tb/tb_carrier_generator_timer.sv
`timescale 1ns/1ps
`include "cgt_map.svh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %s expected %0h seen %0h", n, e, g); end end
module tb_carrier_generator_timer;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, mon_clr;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [2:0] env_clk_sel;
  logic carrier_out_pin, carrier_timer_irq, envelope_sync_irq;
  logic [15:0] last_high, last_low, min_high;
  int errors = 0, check_count = 0, cycles = 0, irqs = 0, syncs = 0, n;
  cgt_top dut (.*);
  cgt_pin_monitor mon (.aclk(aclk), .aresetn(aresetn), .clr(mon_clr),
    .pin(carrier_out_pin), .last_high(last_high), .last_low(last_low),
    .min_high(min_high));
  initial
  begin
    aclk = 0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    cycles++;
    irqs += int'(carrier_timer_irq === 1'b1);
    syncs += int'(envelope_sync_irq === 1'b1);
    if (cycles == 20000)
    begin
      errors++;
      print_verdict();
    end
  end
  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      aw_ok = aw_ok | (s_axi_awready === 1'b1);
      w_ok = w_ok | (s_axi_wready === 1'b1);
      s_axi_awvalid <= !aw_ok;
      s_axi_wvalid <= !w_ok;
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task rd_reg(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd_reg
  task wait_sync;
    do @(posedge aclk); while (envelope_sync_irq !== 1'b1);
  endtask : wait_sync
  task t_regs;
    logic [31:0] exp [6];
    exp = '{32'h0, 32'h1, 32'h1, 32'h0, 32'h1, 32'h0};
    for (int i = 0; i < 6; i++)
    begin
      rd_reg(8'(i * 4));
      `CHK("reset value", exp[i], rd)
      `CHK("read resp", `CGT_RESP_OKAY, rsp)
    end
    rd_reg(8'h18);
    `CHK("unmapped read", {`CGT_RESP_SLVERR, 32'h0}, {rsp, rd})
    wr(8'h18, 32'h1);
    `CHK("unmapped write", `CGT_RESP_SLVERR, rsp)
    wr(`CGT_OUTCTL_OFF, 32'h5);
    rd_reg(`CGT_OUTCTL_OFF);
    `CHK("active read only", 32'h1, rd)
    wr(`CGT_OUTCTL_OFF, 32'h0);
    $display("t_regs done");
  endtask : t_regs
  task t_carrier(input logic [2:0] sel);
    int t;
    t = 1 << sel;
    env_clk_sel <= sel + 3'h3;
    wr(`CGT_LOW_OFF, 32'h3);
    wr(`CGT_HIGH_OFF, 32'h5);
    wr(`CGT_ENV_OFF, 32'h2);
    wr(`CGT_OUTCTL_OFF, 32'h3);
    wr(`CGT_STAT_OFF, 32'h1);
    rd_reg(`CGT_STAT_OFF);
    `CHK("sync flag clear", 1'b0, rd[0])
    mon_clr <= 1'b1;
    wr(`CGT_CTRL_OFF, 32'({sel, 4'h3}));
    mon_clr <= 1'b0;
    wait_sync();
    repeat (40 * t) @(posedge aclk);
    `CHK("high run", 16'(6 * t), last_high)
    `CHK("low run", 16'(4 * t), last_low)
    rd_reg(`CGT_STAT_OFF);
    `CHK("sync flag", 1'b1, rd[0])
    wait_sync();
    wr(`CGT_OUTCTL_OFF, 32'h2);
    wait_sync();
    repeat (30 * t) @(posedge aclk);
    `CHK("pin gated", 1'b0, carrier_out_pin)
    `CHK("whole pulses", 16'(6 * t), min_high)
    wr(`CGT_CTRL_OFF, 32'h0);
    repeat (4) @(posedge aclk);
    n = irqs;
    repeat (50 * t) @(posedge aclk);
    `CHK("irq after stop", n, irqs)
    $display("t_carrier done");
  endtask : t_carrier
  task t_width;
    env_clk_sel <= 3'h3;
    wr(`CGT_HIGH_OFF, 32'h2);
    wr(`CGT_OUTCTL_OFF, 32'h3);
    wr(`CGT_CTRL_OFF, 32'h3);
    wait_sync();
    repeat (40) @(posedge aclk);
    `CHK("restart width", 16'd3, last_high)
    wr(`CGT_HIGH_OFF, 32'h4);
    repeat (40) @(posedge aclk);
    `CHK("new width", 16'd5, last_high)
    `CHK("low kept", 16'd4, last_low)
    do @(posedge aclk); while (carrier_out_pin !== 1'b1);
    wr(`CGT_CTRL_OFF, 32'h0);
    repeat (3) @(posedge aclk);
    `CHK("pin default", 1'b0, carrier_out_pin)
    $display("t_width done");
  endtask : t_width
  task t_level;
    wr(`CGT_OUTCTL_OFF, 32'h0);
    wr(`CGT_CTRL_OFF, 32'h1);
    n = syncs;
    repeat (100) @(posedge aclk);
    `CHK("envelope idle", n, syncs)
    wr(`CGT_CTRL_OFF, 32'h3);
    wait_sync();
    wr(`CGT_OUTCTL_OFF, 32'h1);
    wait_sync();
    n = 0;
    while (carrier_out_pin !== 1'b1 && n < 8)
    begin
      @(posedge aclk);
      n++;
    end
    `CHK("transfer delay", 1'b1, n >= 2 && n <= 4)
    rd_reg(`CGT_OUTCTL_OFF);
    `CHK("active copy", 32'h5, rd)
    repeat (30) @(posedge aclk);
    `CHK("pin level", 1'b1, carrier_out_pin)
    wr(`CGT_CTRL_OFF, 32'h0);
    $display("t_level done");
  endtask : t_level
  initial
  begin
    aresetn = 0;
    s_axi_awvalid = 0;
    s_axi_wvalid = 0;
    s_axi_bready = 0;
    s_axi_arvalid = 0;
    s_axi_rready = 0;
    s_axi_awaddr = 0;
    s_axi_araddr = 0;
    s_axi_wdata = 0;
    s_axi_wstrb = 4'h1;
    env_clk_sel = 3'h3;
    mon_clr = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_carrier(3'h0);
    t_carrier(3'h1);
    t_width();
    t_level();
    print_verdict();
  end
endmodule : tb_carrier_generator_timer
